// [core/pts_map.svh]
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH

// register pages and offsets, word index = {page, offset}, byte address = 4 * index
`define PTS_PG_CFG       5'h02
`define PTS_PG_CTRL_LO   5'h07
`define PTS_PG_CTRL_HI   5'h08
`define PTS_PG_MSG_LO    5'h0F
`define PTS_PG_MSG_HI    5'h10
`define PTS_OFF_CFG      5'h13
`define PTS_OFF_STAT     5'h14
`define PTS_OFF_SLOT_BIT 4

// field positions
`define PTS_CFG_SEL_BIT  0
`define PTS_STAT_LOCK    16

// reset values and masks
`define PTS_CTRL_RST     8'h00
`define PTS_CTRL_WMASK   8'hFC
`define PTS_MSG_RST      8'h00
`define PTS_PRBS_SEED    15'h7FFF
`define PTS_ERR_MAX      16'hFFFF

// checker needs this many straight matches before it declares lock
`define PTS_LOCK_CNT     4'hF

// a-law digital milliwatt, eight bytes sent first byte first
`define PTS_MW_SEQ       64'h34212134B4A1A1B4

`endif

// [core/pts_pkg.sv]
package pts_pkg;

    typedef struct packed {
        logic       tx_buffer_source;
        logic       alt_bit_invert;
        logic       line_side_loopback;
        logic       backplane_side_loopback;
        logic       tx_test_enable;
        logic       rx_test_enable;
        logic [1:0] unused;
    } pts_ctrl_t;

    typedef enum logic {
        CHK_HUNT = 1'b0,
        CHK_LOCK = 1'b1
    } pts_chk_t;

endpackage

// [core/pts_mem_if.sv]
interface pts_mem_if;
    logic [4:0] h_addr;
    logic       h_we;
    logic [7:0] h_wdata;
    logic [7:0] h_rdata;
    logic [4:0] s_addr;
    logic [7:0] s_rdata;

    modport ctl (
        output h_addr,
        output h_we,
        output h_wdata,
        output s_addr,
        input  h_rdata,
        input  s_rdata
    );

    modport mem (
        input  h_addr,
        input  h_we,
        input  h_wdata,
        input  s_addr,
        output h_rdata,
        output s_rdata
    );
endinterface

// [core/pts_slot_mem.sv]
module pts_slot_mem (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // host and stream ports
    pts_mem_if.mem port
);
    logic [7:0] word_r [0:31];
    logic [7:0] h_rdata_r;
    logic [7:0] s_rdata_r;

    // kept in flops so every word has a defined reset value
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_word
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    word_r[gi] <= 8'h00;
                end else if (ce && port.h_we && (port.h_addr == 5'(gi))) begin
                    word_r[gi] <= port.h_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_rdata_r <= 8'h00;
            s_rdata_r <= 8'h00;
        end else if (ce) begin
            h_rdata_r <= word_r[port.h_addr];
            s_rdata_r <= word_r[port.s_addr];
        end
    end

    assign port.h_rdata = h_rdata_r;
    assign port.s_rdata = s_rdata_r;
endmodule

// [core/pts_slot_ctrl.sv]
// What this block does
// [RULE1] low page words drive slots 0 to 15
// [RULE2] high page words drive slots 16 to 31
// [RULE3] message bit sends buffer byte instead
// [RULE4] message bit clear sends backplane input byte
// [RULE5] message buffer reached as two pages
// [RULE6] alternate bit inversion on transmit and receive
// [RULE7] line loopback, received data still reaches backplane
// [RULE8] backplane loopback, transmit data still sent out
// [RULE9] transmit test with select one sends milliwatt
// [RULE10] transmit test with select zero sends prbs
// [RULE11] test pattern runs on across enabled slots
// [RULE12] receive test with select one outputs milliwatt
// [RULE13] receive test with select zero checks prbs
// [RULE14] test bits clear leave test circuits detached
// [RULE15] words reset zero, bits one and zero read zero
// [RULE16] new control word takes effect at slot start
//
// The implementer's own choice: the APB register port.
`include "pts_map.svh"

module pts_slot_ctrl (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bit timing
    input wire logic bit_strobe,
    input wire logic frame_sync,
    // serial streams
    input wire logic backplane_serial_in,
    input wire logic line_rx_in,
    output logic backplane_serial_out,
    output logic line_tx_out
);
    pts_mem_if cif ();
    pts_mem_if mif ();

    pts_slot_mem u_ctrl_mem (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .port(cif.mem)
    );

    pts_slot_mem u_msg_mem (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .port(mif.mem)
    );

    // ---------------- register decode ----------------
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic sel_r;
    wire [4:0] reg_page = paddr[11:7];
    wire [4:0] reg_off = paddr[6:2];
    wire slot_off = reg_off[`PTS_OFF_SLOT_BIT];
    wire hit_ctrl_lo = (reg_page == `PTS_PG_CTRL_LO) && slot_off;
    wire hit_ctrl_hi = (reg_page == `PTS_PG_CTRL_HI) && slot_off;
    wire hit_msg_lo = (reg_page == `PTS_PG_MSG_LO) && slot_off;
    wire hit_msg_hi = (reg_page == `PTS_PG_MSG_HI) && slot_off;
    wire hit_ctrl = hit_ctrl_lo || hit_ctrl_hi;
    wire hit_msg = hit_msg_lo || hit_msg_hi;
    wire hit_cfg = (reg_page == `PTS_PG_CFG) && (reg_off == `PTS_OFF_CFG);
    wire hit_stat = (reg_page == `PTS_PG_CFG) && (reg_off == `PTS_OFF_STAT);
    wire hit_any = hit_ctrl || hit_msg || hit_cfg || hit_stat;
    // one wait state: memory read data is registered
    wire acc_first = psel && penable && !pready_r;
    wire wr_go = psel && penable && pready_r && pwrite;
    wire [4:0] host_slot = {hit_ctrl_hi || hit_msg_hi, reg_off[3:0]};

    assign cif.h_addr = host_slot; // [RULE1] [RULE2]
    assign cif.h_we = wr_go && hit_ctrl;
    assign cif.h_wdata = pwdata[7:0] & `PTS_CTRL_WMASK; // [RULE15]
    assign mif.h_addr = host_slot; // [RULE5]
    assign mif.h_we = wr_go && hit_msg;
    assign mif.h_wdata = pwdata[7:0];

    // ---------------- slot and bit position ----------------
    logic [2:0] bit_r;
    logic [4:0] slot_r;
    pts_pkg::pts_ctrl_t act_r;
    logic [7:0] msg_act_r;
    wire tick = ce && bit_strobe;
    wire [2:0] cur_bit = frame_sync ? 3'h0 : bit_r;
    wire slot_start = (cur_bit == 3'h0);

    assign cif.s_addr = slot_r; // [RULE1] [RULE2]
    assign mif.s_addr = slot_r;

    // word is fetched ahead and frozen for the whole slot
    wire pts_pkg::pts_ctrl_t ctrl_now = slot_start ? pts_pkg::pts_ctrl_t'(cif.s_rdata) : act_r; // [RULE16]
    wire [7:0] msg_now = slot_start ? mif.s_rdata : msg_act_r;

    // ---------------- datapath ----------------
    logic [14:0] prbs_r;
    logic [2:0] tx_mw_ph_r;
    logic [2:0] rx_mw_ph_r;
    logic backplane_serial_out_r;
    logic line_tx_out_r;
    wire adi_mask = ctrl_now.alt_bit_invert && cur_bit[0]; // [RULE6]
    wire msg_bit = msg_now[3'h7 - cur_bit];
    wire bp_bit = backplane_serial_in ^ adi_mask; // [RULE6]
    wire rx_bit = line_rx_in ^ adi_mask; // [RULE6]
    wire tx_src = ctrl_now.tx_buffer_source ? msg_bit : bp_bit; // [RULE3] [RULE4]
    wire [63:0] mw_tx_sh = `PTS_MW_SEQ << {tx_mw_ph_r, cur_bit};
    wire [63:0] mw_rx_sh = `PTS_MW_SEQ << {rx_mw_ph_r, cur_bit};
    wire tx_test_on = ctrl_now.tx_test_enable && !ctrl_now.line_side_loopback; // [RULE14]
    wire tx_mw_use = tx_test_on && sel_r; // [RULE9]
    wire tx_prbs_use = tx_test_on && !sel_r; // [RULE10]
    wire rx_mw_use = ctrl_now.rx_test_enable && sel_r && !ctrl_now.backplane_side_loopback;
    wire chk_use = ctrl_now.rx_test_enable && !sel_r; // [RULE13] [RULE14]
    wire tx_test_bit = sel_r ? mw_tx_sh[63] : prbs_r[14];
    wire line_bit = ctrl_now.line_side_loopback ? line_rx_in : // [RULE7]
                    tx_test_on ? tx_test_bit : tx_src; // [RULE9] [RULE10]
    wire bp_out_bit = ctrl_now.backplane_side_loopback ? tx_src : // [RULE8]
                      rx_mw_use ? mw_rx_sh[63] : rx_bit; // [RULE12] [RULE7]
    wire [14:0] prbs_nxt = {prbs_r[13:0], prbs_r[14] ^ prbs_r[13]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_r <= 3'h0;
            slot_r <= 5'h00;
            act_r <= pts_pkg::pts_ctrl_t'(`PTS_CTRL_RST);
            msg_act_r <= `PTS_MSG_RST;
        end else if (tick) begin
            bit_r <= cur_bit + 3'h1;
            slot_r <= (frame_sync ? 5'h00 : slot_r) + {4'h0, cur_bit == 3'h7};
            act_r <= ctrl_now; // [RULE16]
            msg_act_r <= msg_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_tx_out_r <= 1'b0;
            backplane_serial_out_r <= 1'b0;
        end else if (tick) begin
            line_tx_out_r <= line_bit;
            backplane_serial_out_r <= bp_out_bit;
        end
    end

    // generator and milliwatt phases only move in enabled slots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prbs_r <= `PTS_PRBS_SEED;
            tx_mw_ph_r <= 3'h0;
            rx_mw_ph_r <= 3'h0;
        end else if (tick) begin
            if (tx_prbs_use) begin
                prbs_r <= prbs_nxt; // [RULE10] [RULE11]
            end
            if (tx_mw_use && cur_bit == 3'h7) begin
                tx_mw_ph_r <= tx_mw_ph_r + 3'h1; // [RULE11]
            end
            if (rx_mw_use && cur_bit == 3'h7) begin
                rx_mw_ph_r <= rx_mw_ph_r + 3'h1;
            end
        end
    end

    // ---------------- prbs checker ----------------
    pts_pkg::pts_chk_t chk_st_r;
    pts_pkg::pts_chk_t chk_st_nxt;
    logic [14:0] chk_sh_r;
    logic [3:0] match_cnt_r;
    logic [3:0] match_cnt_nxt;
    logic [15:0] err_cnt_r;
    logic [15:0] err_cnt_nxt;
    wire chk_tick = tick && chk_use;
    wire chk_pred = chk_sh_r[14] ^ chk_sh_r[13];
    wire chk_miss = chk_tick && (rx_bit != chk_pred);
    wire stat_clr = wr_go && hit_stat;
    wire err_inc = chk_miss && (chk_st_r == pts_pkg::CHK_LOCK);

    always_comb begin
        chk_st_nxt = chk_st_r;
        match_cnt_nxt = match_cnt_r;
        err_cnt_nxt = err_cnt_r;
        if (stat_clr) begin
            err_cnt_nxt = 16'h0000;
            chk_st_nxt = pts_pkg::CHK_HUNT;
            match_cnt_nxt = 4'h0;
        end
        // a miss in the clearing cycle still counts
        if (err_inc && err_cnt_nxt != `PTS_ERR_MAX) begin
            err_cnt_nxt = err_cnt_nxt + 16'h0001; // [RULE13]
        end
        if (chk_tick && chk_st_r == pts_pkg::CHK_HUNT && !stat_clr) begin
            unique case (chk_miss)
                1'b1: match_cnt_nxt = 4'h0;
                1'b0: begin
                    match_cnt_nxt = match_cnt_r + 4'h1;
                    if (match_cnt_nxt == `PTS_LOCK_CNT) begin
                        chk_st_nxt = pts_pkg::CHK_LOCK; // [RULE13]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_st_r <= pts_pkg::CHK_HUNT;
            chk_sh_r <= 15'h0000;
            match_cnt_r <= 4'h0;
            err_cnt_r <= 16'h0000;
        end else if (ce) begin
            chk_st_r <= chk_st_nxt;
            match_cnt_r <= match_cnt_nxt;
            err_cnt_r <= err_cnt_nxt;
            if (chk_tick) begin
                chk_sh_r <= {chk_sh_r[13:0], rx_bit}; // [RULE13]
            end
        end
    end

    // ---------------- apb answer ----------------
    wire [31:0] stat_word = {15'h0000, chk_st_r == pts_pkg::CHK_LOCK, err_cnt_r};
    wire [31:0] rd_val = hit_ctrl ? {24'h000000, cif.h_rdata & `PTS_CTRL_WMASK} : // [RULE15]
                         hit_msg ? {24'h000000, mif.h_rdata} :
                         hit_cfg ? {31'h00000000, sel_r} :
                         hit_stat ? stat_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
            sel_r <= 1'b0;
        end else if (ce) begin
            pready_r <= acc_first;
            pslverr_r <= acc_first && !hit_any;
            if (acc_first) begin
                prdata_r <= pwrite ? 32'h00000000 : rd_val;
            end
            if (wr_go && hit_cfg) begin
                sel_r <= pwdata[`PTS_CFG_SEL_BIT];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign backplane_serial_out = backplane_serial_out_r;
    assign line_tx_out = line_tx_out_r;

    // ---------------- assertions ----------------
    property p_unused_zero;
        @(posedge pclk) disable iff (!presetn)
        tick |-> (ctrl_now.unused == 2'b00);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused control bits set"); // [RULE15]

    property p_msg_src;
        @(posedge pclk) disable iff (!presetn)
        (tick && ctrl_now.tx_buffer_source && !ctrl_now.line_side_loopback &&
         !ctrl_now.tx_test_enable) |=> (line_tx_out_r == $past(msg_bit));
    endproperty
    a_msg_src: assert property (p_msg_src) else $error("message byte not sent"); // [RULE3]

    property p_bp_src;
        @(posedge pclk) disable iff (!presetn)
        (tick && !ctrl_now.tx_buffer_source && !ctrl_now.line_side_loopback &&
         !ctrl_now.tx_test_enable && !adi_mask) |=> (line_tx_out_r == $past(backplane_serial_in));
    endproperty
    a_bp_src: assert property (p_bp_src) else $error("backplane byte not sent"); // [RULE4]

    property p_adi;
        @(posedge pclk) disable iff (!presetn)
        (tick && ctrl_now.alt_bit_invert && cur_bit[0] && !ctrl_now.tx_buffer_source &&
         !ctrl_now.line_side_loopback && !ctrl_now.tx_test_enable)
        |=> (line_tx_out_r != $past(backplane_serial_in));
    endproperty
    a_adi: assert property (p_adi) else $error("alternate bit not inverted"); // [RULE6]

    property p_line_loop;
        @(posedge pclk) disable iff (!presetn)
        (tick && ctrl_now.line_side_loopback) |=> (line_tx_out_r == $past(line_rx_in));
    endproperty
    a_line_loop: assert property (p_line_loop) else $error("line loopback broken"); // [RULE7]

    property p_bp_loop;
        @(posedge pclk) disable iff (!presetn)
        (tick && ctrl_now.backplane_side_loopback) |=> (backplane_serial_out_r == $past(tx_src));
    endproperty
    a_bp_loop: assert property (p_bp_loop) else $error("backplane loopback broken"); // [RULE8]

    property p_prbs_tx;
        @(posedge pclk) disable iff (!presetn)
        (tick && tx_prbs_use) |=> (line_tx_out_r == $past(prbs_r[14])) && (prbs_r != $past(prbs_r));
    endproperty
    a_prbs_tx: assert property (p_prbs_tx) else $error("prbs not sent"); // [RULE10]

    property p_mw_tx;
        @(posedge pclk) disable iff (!presetn)
        (tick && tx_mw_use) |=> (line_tx_out_r == $past(mw_tx_sh[63]));
    endproperty
    a_mw_tx: assert property (p_mw_tx) else $error("milliwatt not sent"); // [RULE9]

    property p_mw_rx;
        @(posedge pclk) disable iff (!presetn)
        (tick && rx_mw_use) |=> (backplane_serial_out_r == $past(mw_rx_sh[63]));
    endproperty
    a_mw_rx: assert property (p_mw_rx) else $error("milliwatt not on backplane"); // [RULE12]

    property p_detached;
        @(posedge pclk) disable iff (!presetn)
        !(tick && tx_prbs_use) |=> $stable(prbs_r);
    endproperty
    a_detached: assert property (p_detached) else $error("prbs moved in unselected slot"); // [RULE14]

    property p_slot_hold;
        @(posedge pclk) disable iff (!presetn)
        !(tick && slot_start) |=> $stable(act_r);
    endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("control word changed mid slot"); // [RULE16]

    property p_chk_err;
        @(posedge pclk) disable iff (!presetn)
        (err_inc && !stat_clr && err_cnt_r != `PTS_ERR_MAX) |=> (err_cnt_r == $past(err_cnt_r) + 16'h0001);
    endproperty
    a_chk_err: assert property (p_chk_err) else $error("checker miss not counted"); // [RULE13]
endmodule

// [sim/pts_bp_model.sv]
module pts_bp_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bit timing and backplane pins
    output logic bit_strobe,
    output logic frame_sync,
    output logic backplane_serial_in,
    input wire logic backplane_serial_out,
    // byte tables and stream position
    input wire logic [7:0] tx_byte [32],
    output logic [7:0] rx_byte [32],
    output logic [7:0] pos_r,
    output logic [1:0] ph_r,
    output logic [15:0] frames_r
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last;
    assign last = pos_r - 8'h01;
    // one strobe every four clocks, comfortably above the two-cycle minimum
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= 2'h0;
            pos_r <= 8'h00;
            bit_strobe <= 1'b0;
            frame_sync <= 1'b0;
            backplane_serial_in <= 1'b0;
            frames_r <= 16'h0000;
        end else begin
            ph_r <= ph_r + 2'h1;
            bit_strobe <= (ph_r == 2'h2);
            frame_sync <= (ph_r == 2'h2) && (pos_r == 8'h00);
            // toggles between strobes so a stale bit is never mistaken for data
            backplane_serial_in <= (ph_r == 2'h2) ? tx_byte[pos_r[7:3]][~pos_r[2:0]]
                                                  : ~backplane_serial_in;
            if (ph_r == 2'h3)
                pos_r <= pos_r + 8'h01;
            if (ph_r == 2'h0) begin
                rx_byte[last[7:3]][~last[2:0]] <= backplane_serial_out;
                if (last == 8'hFF)
                    frames_r <= frames_r + 16'h0001;
            end
        end
    end
endmodule

// [sim/tb_per_timeslot_control.sv]
`include "pts_map.svh"

module tb_per_timeslot_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, erv, echo;
    logic bit_strobe, frame_sync, backplane_serial_in, backplane_serial_out, line_tx_out;
    logic line_rx_in = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] bp_tx [32], bp_rx [32], ln_drv [32], ln_cap [32], ctl [32], msg [32];
    logic [7:0] ln_rnd [32];
    logic [7:0] pos_r, lpos;
    logic [1:0] ph_r;
    logic [15:0] frames_r;
    int n_fail, samples_checked;
    localparam logic [11:0] cfg_a = {`PTS_PG_CFG, `PTS_OFF_CFG, 2'b00};
    localparam logic [11:0] st_a = {`PTS_PG_CFG, `PTS_OFF_STAT, 2'b00};

    pts_slot_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_strobe(bit_strobe), .frame_sync(frame_sync),
        .backplane_serial_in(backplane_serial_in), .line_rx_in(line_rx_in),
        .backplane_serial_out(backplane_serial_out), .line_tx_out(line_tx_out));
    pts_bp_model bp (.pclk(pclk), .presetn(presetn), .bit_strobe(bit_strobe),
        .frame_sync(frame_sync), .backplane_serial_in(backplane_serial_in),
        .backplane_serial_out(backplane_serial_out), .tx_byte(bp_tx), .rx_byte(bp_rx),
        .pos_r(pos_r), .ph_r(ph_r), .frames_r(frames_r));

    // line side: same bit timing as the backplane, optional one-frame echo
    assign lpos = pos_r - 8'h01;
    always @(posedge pclk) begin
        line_rx_in <= (ph_r == 2'h2) ? ln_drv[pos_r[7:3]][~pos_r[2:0]] : ~line_rx_in;
        // random bytes while echo is off, so this block alone drives the line table
        if (!echo) begin
            ln_drv <= ln_rnd;
        end
        if (ph_r == 2'h0) begin
            ln_cap[lpos[7:3]][~lpos[2:0]] <= line_tx_out;
            if (lpos == 8'hFF && echo)
                ln_drv <= ln_cap;
        end
    end

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_reg({24'h0, got}, {24'h0, exp});
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    task automatic endt(input string t);
        $display("test %s done, %0d mismatches so far", t, n_fail);
    endtask

    // called right after a clock edge; leaves one idle cycle behind it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            summarize();
        end
        @(posedge pclk);
    endtask

    task automatic wait_frames(input int n);
        int t;
        t = frames_r + n;
        for (int i = 0; i < 1100 * n && frames_r < t; i++)
            @(posedge pclk);
        if (frames_r < t) begin
            n_fail++;
            summarize();
        end
    endtask

    function automatic logic [11:0] ca(input int s, input logic [4:0] lo, input logic [4:0] hi);
        return {(s > 15) ? hi : lo, 5'h10 + 5'(s % 16), 2'b00};
    endfunction

    function automatic logic [7:0] src(input pts_pkg::pts_ctrl_t c, input logic [7:0] m,
                                       input logic [7:0] b);
        return c.tx_buffer_source ? m : (c.alt_bit_invert ? b ^ 8'h55 : b);
    endfunction

    function automatic logic [63:0] pk(input logic [7:0] a [32], input int b, input int n);
        logic [63:0] v;
        v = 64'h0;
        for (int s = b; s < b + n; s++)
            v = {v[55:0], a[s]};
        return v;
    endfunction

    function automatic logic mw_ok(input logic [63:0] v);
        for (int p = 0; p < 8; p++)
            if (((v << 8 * p) | (v >> (64 - 8 * p))) === `PTS_MW_SEQ)
                return 1'b1;
        return 1'b0;
    endfunction

    function automatic logic prbs_ok(input logic [31:0] b);
        for (int n = 15; n < 32; n++)
            if (b[31 - n] !== (b[45 - n] ^ b[46 - n]))
                return 1'b0;
        return |b;
    endfunction

    initial begin
        pts_pkg::pts_ctrl_t cw;
        logic [7:0] x;
        logic [1:0] hold;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        echo = 1'b0;
        for (int s = 0; s < 32; s++) begin
            bp_tx[s] = 8'h00;
            ln_rnd[s] = 8'h00;
        end
        void'($urandom(90240));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ca(16, `PTS_PG_CTRL_LO, `PTS_PG_CTRL_HI), 32'h0);
        chk_reg(rdv, 32'h0);
        apb(1'b0, ca(31, `PTS_PG_MSG_LO, `PTS_PG_MSG_HI), 32'h0);
        chk_reg(rdv, 32'h0);
        apb(1'b1, ca(31, `PTS_PG_CTRL_LO, `PTS_PG_CTRL_HI), 32'hFFFF_FFFF);
        apb(1'b0, ca(31, `PTS_PG_CTRL_LO, `PTS_PG_CTRL_HI), 32'h0);
        chk_reg(rdv, 32'h0000_00FC);
        apb(1'b0, 12'h3BC, 32'h0);
        chk_flag(erv, 1'b1);
        endt("registers");
        // random words and data, select toggled between rounds
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, cfg_a, 32'(r % 2));
            for (int s = 0; s < 32; s++) begin
                ctl[s] = 8'($urandom) & 8'hF0;
                msg[s] = 8'($urandom);
                bp_tx[s] <= 8'($urandom);
                ln_rnd[s] <= 8'($urandom);
                apb(1'b1, ca(s, `PTS_PG_CTRL_LO, `PTS_PG_CTRL_HI), {24'h0, ctl[s]});
                apb(1'b1, ca(s, `PTS_PG_MSG_LO, `PTS_PG_MSG_HI), {24'h0, msg[s]});
            end
            wait_frames(2);
            for (int s = 0; s < 32; s++) begin
                cw = ctl[s];
                x = src(cw, msg[s], bp_tx[s]);
                chk_byte(ln_cap[s], cw.line_side_loopback ? ln_rnd[s] : x);
                x = cw.backplane_side_loopback ? x : ln_rnd[s] ^ (cw.alt_bit_invert ? 8'h55 : 8'h00);
                chk_byte(bp_rx[s], x);
            end
        end
        endt("random slots");
        apb(1'b1, cfg_a, 32'h1);
        for (int s = 0; s < 32; s++)
            apb(1'b1, ca(s, `PTS_PG_CTRL_LO, `PTS_PG_CTRL_HI), (s / 8 == 1) ? 32'h0C : 32'h0);
        wait_frames(2);
        chk_flag(mw_ok(pk(ln_cap, 8, 8)), 1'b1);
        chk_flag(mw_ok(pk(bp_rx, 8, 8)), 1'b1);
        chk_byte(ln_cap[0], bp_tx[0]);
        endt("milliwatt");
        apb(1'b1, cfg_a, 32'h0);
        for (int s = 0; s < 32; s++)
            apb(1'b1, ca(s, `PTS_PG_CTRL_LO, `PTS_PG_CTRL_HI), (s / 4 == 5) ? 32'h0C : 32'h0);
        // echo starts only once a whole frame carries the sequence
        wait_frames(1);
        echo <= 1'b1;
        wait_frames(3);
        chk_flag(prbs_ok(32'(pk(ln_cap, 20, 4))), 1'b1);
        apb(1'b0, st_a, 32'h0);
        chk_reg(rdv, 32'h0001_0000);
        echo <= 1'b0;
        wait_frames(1);
        echo <= 1'b1;
        wait_frames(1);
        apb(1'b0, st_a, 32'h0);
        chk_flag(rdv[16] && (rdv[15:0] != 16'h0), 1'b1);
        apb(1'b1, st_a, 32'h0);
        apb(1'b0, st_a, 32'h0);
        chk_reg(rdv, 32'h0);
        endt("prbs");
        // ce low freezes slot state, so both streams must hold their last bit
        ce <= 1'b0;
        @(posedge pclk);
        hold = {line_tx_out, backplane_serial_out};
        repeat (40) begin
            @(posedge pclk);
            chk_byte({6'h00, line_tx_out, backplane_serial_out}, {6'h00, hold});
        end
        ce <= 1'b1;
        endt("clock enable");
        summarize();
    end
endmodule
